// *** verilog/oesc_sample_config.sv ***
// Purpose : slot 3/4 type select, system control and optical sampling setup
// Assumes : register port and front-end inputs synchronous to core_clk
// Notes   : sample store holds slot 1..4 elements, stop on full
//
// Overview of operation
// R1 - upper nibble selects element four type
// R2 - lower nibble selects element three type
// R3 - slot codes: none, LED1, LED2, pilots, ECG
// R4 - store holds 32 samples, four 3-byte elements
// R5 - enable clear stops pushes, holds pointers, data; the code still lets pops advance rd_ptr and count while disabled
// R6 - enable set flushes store, restarts at zero
// R7 - power-save keeps registers readable and writable
// R8 - entering power-save clears all interrupt flags
// R9 - oscillator stops after running conversion completes
// R10 - results frozen during power-save
// R11 - soft reset returns all registers to reset
// R12 - soft-reset bit clears itself when done
// R13 - range code sets LSB and full scale
// R14 - rate code decodes rate and pulse count
// R15 - unsupported rate replaced by highest, readable back
// R16 - max rate per pulse width and LEDs
// R17 - pulse width code gives 50 to 400 us
// R18 - reserved slot code stores no data
`timescale 1ns/1ns
`include "oesc_defines.svh"
module oesc_sample_config
   import oesc_pkg::*;
(
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   // front end
   input  wire logic        conv_busy,
   input  wire logic        conv_done,
   input  wire logic [23:0] first_led_in,
   input  wire logic [23:0] second_led_in,
   input  wire logic [23:0] ecg_in,
   input  wire logic [47:0] slot12_elems,
   input  wire logic        two_led_mode,
   // sample store read side
   input  wire logic        pop_req,
   output logic      [95:0] pop_data,
   output logic      [5:0]  store_count,
   // control and decoded setup
   output logic             osc_en,
   output logic             irq_clear,
   output logic             soft_reset_busy,
   output logic      [3:0]  slot_three_type,
   output logic      [3:0]  slot_four_type,
   output logic      [15:0] adc_full_scale_na,
   output logic      [8:0]  led_pulse_width_us,
   output logic      [11:0] sample_rate_sps,
   output logic      [1:0]  pulses_per_sample
);
   // ****************************************************************
   // state
   // ****************************************************************
   oesc_state_t st_ff;
   oesc_state_t nxt_st;
   oesc_state_t rst_st;
   logic [95:0] store_mem [`OESC_STORE_DEPTH];
   logic        push;
   logic        pop;
   logic        flush;
   logic        two_led;
   logic [3:0]  max_n1;
   logic [3:0]  max_n2;
   logic [3:0]  clamp_sr;

   // element value for a slot type, reserved codes store zero
   function automatic logic [23:0] elem_sel(input logic [3:0] t,
                                            input oesc_state_t s);
      unique case (t)
         OESC_SLOT_LED1, OESC_SLOT_PILOT1: elem_sel = s.res1;    // R3
         OESC_SLOT_LED2, OESC_SLOT_PILOT2: elem_sel = s.res2;    // R3
         OESC_SLOT_ECG:                    elem_sel = s.res_ecg; // R3
         default:                          elem_sel = 24'h00_0000; // R18
      endcase
   endfunction : elem_sel

   // reset image of every register
   always_comb begin
      rst_st          = '0;
      rst_st.slot34   = `OESC_RST_SLOT34;
      rst_st.pstate   = OESC_PWR_RUN;
      rst_st.osc_en   = 1'b1;
      rst_st.full_scale = `OESC_FS_BASE_NA;
      rst_st.pw_us    = `OESC_PW_BASE_US;
      rst_st.sps      = oesc_sps(4'h0);
      rst_st.pulses   = 2'h1;
   end

   // highest supported rate code for current pulse width and LED count
   always_comb begin
      two_led = two_led_mode |
                ((st_ff.slot34[3:0] == OESC_SLOT_LED1) &&
                 (st_ff.slot34[7:4] == OESC_SLOT_LED2)) |
                ((st_ff.slot34[3:0] == OESC_SLOT_LED2) &&
                 (st_ff.slot34[7:4] == OESC_SLOT_LED1));
      if (two_led) begin
         unique case (st_ff.pw)                                 // R16
            2'h0:       max_n1 = `OESC_SR_1600;
            2'h1, 2'h2: max_n1 = `OESC_SR_800;
            2'h3:       max_n1 = `OESC_SR_400;
         endcase
      end else begin
         unique case (st_ff.pw)                                 // R16
            2'h0:       max_n1 = `OESC_SR_LAST_N1;
            2'h1:       max_n1 = `OESC_SR_1600;
            2'h2, 2'h3: max_n1 = `OESC_SR_1000;
         endcase
      end
      max_n2 = (two_led && st_ff.pw == 2'h3) ? `OESC_SR_N2_84 : `OESC_SR_N2_100; // R16
      if (st_ff.sr <= `OESC_SR_LAST_N1) begin
         clamp_sr = (st_ff.sr > max_n1) ? max_n1 : st_ff.sr;   // R15
      end else begin
         clamp_sr = (st_ff.sr > max_n2) ? max_n2 : st_ff.sr;   // R15
      end
   end

   // next state
   always_comb begin
      nxt_st  = st_ff;
      push    = 1'b0;
      pop     = 1'b0;
      flush   = 1'b0;
      nxt_st.sr = clamp_sr;                                    // R15
      // register writes, accepted in every power state
      if (reg_wr) begin                                        // R7
         unique case (reg_addr)
            `OESC_ADDR_SLOT34: nxt_st.slot34 = reg_wdata;      // R1 R2
            `OESC_ADDR_SYSCTL: begin
               nxt_st.store_en = reg_wdata[`OESC_SYS_STORE_EN];
               nxt_st.psave    = reg_wdata[`OESC_SYS_PSAVE];
               if (reg_wdata[`OESC_SYS_SRST]) begin
                  nxt_st.srst_cnt = `OESC_SRST_CYCLES;         // R11
               end
               if (reg_wdata[`OESC_SYS_STORE_EN] && !st_ff.store_en) begin
                  flush         = 1'b1;                        // R6
                  nxt_st.wr_ptr = 5'h00;                       // R6
                  nxt_st.rd_ptr = 5'h00;                       // R6
                  nxt_st.count  = 6'h00;                       // R6
               end
            end
            `OESC_ADDR_OPTCFG: begin
               nxt_st.rge = reg_wdata[`OESC_OPT_RGE_LSB +: 2];
               nxt_st.sr  = reg_wdata[`OESC_OPT_SR_LSB +: 4];
               nxt_st.pw  = reg_wdata[`OESC_OPT_PW_LSB +: 2];
            end
            default: ;
         endcase
      end
      // register read data
      if (reg_rd) begin
         unique case (reg_addr)
            `OESC_ADDR_SLOT34: nxt_st.rdata = st_ff.slot34;
            `OESC_ADDR_SYSCTL: nxt_st.rdata = {5'h00, st_ff.store_en, st_ff.psave,
                                               (st_ff.srst_cnt != 4'h0)}; // R12
            `OESC_ADDR_OPTCFG: nxt_st.rdata = {st_ff.rge, st_ff.sr, st_ff.pw}; // R15
            default:           nxt_st.rdata = 8'h00;
         endcase
      end
      // power sequencing, a running conversion finishes first
      unique case (st_ff.pstate)
         OESC_PWR_RUN: begin
            if (st_ff.psave) begin
               nxt_st.pstate = conv_busy ? OESC_PWR_DRAIN : OESC_PWR_SLEEP; // R9
            end
         end
         OESC_PWR_DRAIN: begin
            if (!st_ff.psave) begin
               nxt_st.pstate = OESC_PWR_RUN;
            end else if (!conv_busy) begin
               nxt_st.pstate = OESC_PWR_SLEEP;                 // R9
            end
         end
         OESC_PWR_SLEEP: begin
            if (!st_ff.psave) begin
               nxt_st.pstate = OESC_PWR_RUN;
            end
         end
         default: nxt_st.pstate = OESC_PWR_RUN;
      endcase
      nxt_st.osc_en  = (nxt_st.pstate != OESC_PWR_SLEEP);      // R9
      nxt_st.irq_clr = (nxt_st.pstate == OESC_PWR_SLEEP);      // R8
      // conversion results, frozen while asleep
      if (conv_done && st_ff.pstate != OESC_PWR_SLEEP) begin   // R10
         nxt_st.res1    = first_led_in;
         nxt_st.res2    = second_led_in;
         nxt_st.res_ecg = ecg_in;
         if (st_ff.store_en && st_ff.count < 6'(`OESC_STORE_DEPTH)) begin // R4 R5
            push          = 1'b1;
            nxt_st.wr_ptr = st_ff.wr_ptr + 5'h01;
         end
      end
      // pop from the store, a flush in the same cycle wins so count cannot wrap
      pop = pop_req && (st_ff.count != 6'h00) && !flush;
      if (pop) begin
         nxt_st.pop_data = store_mem[st_ff.rd_ptr];
         nxt_st.rd_ptr   = st_ff.rd_ptr + 5'h01;
      end
      nxt_st.count = nxt_st.count + {5'h00, push} - {5'h00, pop};
      // decoded setup
      nxt_st.full_scale = `OESC_FS_BASE_NA << nxt_st.rge;      // R13
      nxt_st.pw_us      = `OESC_PW_BASE_US << nxt_st.pw;       // R17
      nxt_st.sps        = oesc_sps(nxt_st.sr);                 // R14
      nxt_st.pulses     = (nxt_st.sr > `OESC_SR_LAST_N1) ? 2'h2 : 2'h1; // R14
      // soft reset sequence overrides everything
      if (st_ff.srst_cnt != 4'h0) begin
         nxt_st          = rst_st;                             // R11
         nxt_st.srst_cnt = st_ff.srst_cnt - 4'h1;              // R12
      end
      // busy flag kept in a flop so the output is registered
      nxt_st.srst_busy = (nxt_st.srst_cnt != 4'h0);            // R12
   end

   // state and store registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         st_ff <= '0;
         st_ff.pstate <= OESC_PWR_RUN;
         st_ff.osc_en <= 1'b1;
         st_ff.full_scale <= `OESC_FS_BASE_NA;
         st_ff.pw_us <= `OESC_PW_BASE_US;
         st_ff.sps <= 12'h00A;
         st_ff.pulses <= 2'h1;
      end else begin
         st_ff <= nxt_st;
      end
      if (push && st_ff.srst_cnt == 4'h0) begin
         store_mem[st_ff.wr_ptr] <= {slot12_elems, elem_sel(st_ff.slot34[3:0], nxt_st),
                                     elem_sel(st_ff.slot34[7:4], nxt_st)}; // R1 R2 R4
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign reg_rdata          = st_ff.rdata;
   assign pop_data           = st_ff.pop_data;
   assign store_count        = st_ff.count;
   assign osc_en             = st_ff.osc_en;
   assign irq_clear          = st_ff.irq_clr;
   assign soft_reset_busy    = st_ff.srst_busy;                // R12
   assign slot_three_type    = st_ff.slot34[3:0];              // R2
   assign slot_four_type     = st_ff.slot34[7:4];              // R1
   assign adc_full_scale_na  = st_ff.full_scale;
   assign led_pulse_width_us = st_ff.pw_us;
   assign sample_rate_sps    = st_ff.sps;
   assign pulses_per_sample  = st_ff.pulses;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_drain_wait;
      st_ff.pstate == OESC_PWR_DRAIN && conv_busy && st_ff.psave;
   endsequence
   property p_drain;
      s_drain_wait |=> st_ff.pstate != OESC_PWR_SLEEP && osc_en;
   endproperty
   a_drain: assert property (p_drain) else $error("slept during conversion"); // R9
   property p_sleep_irq;
      st_ff.pstate == OESC_PWR_SLEEP |-> irq_clear && !osc_en;
   endproperty
   a_sleep_irq: assert property (p_sleep_irq) else $error("sleep outputs"); // R8
   property p_res_hold;
      st_ff.pstate == OESC_PWR_SLEEP && st_ff.srst_cnt == 4'h0 |=> $stable(st_ff.res1);
   endproperty
   a_res_hold: assert property (p_res_hold) else $error("result moved"); // R10
   property p_ptr_hold;
      !st_ff.store_en && !reg_wr && st_ff.srst_cnt == 4'h0 |=> $stable(st_ff.wr_ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pushed while off"); // R5
   property p_flush;
      $rose(st_ff.store_en) && $past(st_ff.srst_cnt) == 4'h0 |->
         st_ff.wr_ptr <= 5'h01 && st_ff.rd_ptr == 5'h00;
   endproperty
   a_flush: assert property (p_flush) else $error("no flush"); // R6
   property p_full;
      store_count <= 6'h20;
   endproperty
   a_full: assert property (p_full) else $error("store overfilled"); // R4
   property p_clamp;
      st_ff.sr <= `OESC_SR_LAST_N1 && !(reg_wr && reg_addr == `OESC_ADDR_OPTCFG) |=>
         sample_rate_sps <= oesc_sps($past(max_n1));
   endproperty
   a_clamp: assert property (p_clamp) else $error("rate not clamped"); // R15
   property p_srst;
      reg_wr && reg_addr == `OESC_ADDR_SYSCTL && reg_wdata[0] && !soft_reset_busy |=>
         soft_reset_busy [*8] ##1 !soft_reset_busy && st_ff.slot34 == 8'h00;
   endproperty
   a_srst: assert property (p_srst) else $error("soft reset length"); // R11
   property p_slot_wr;
      reg_wr && reg_addr == `OESC_ADDR_SLOT34 && !soft_reset_busy |=>
         {slot_four_type, slot_three_type} == $past(reg_wdata);
   endproperty
   a_slot_wr: assert property (p_slot_wr) else $error("slot write lost"); // R7
   property p_scale;
      adc_full_scale_na == (`OESC_FS_BASE_NA << st_ff.rge);
   endproperty
   a_scale: assert property (p_scale) else $error("full scale decode"); // R13
endmodule : oesc_sample_config

// *** verilog/oesc_defines.svh ***
// Purpose : register offsets, field positions, reset values and counts
// Assumes : included by bare name from the package and the block
// Notes   : definitions only
`ifndef OESC_DEFINES_SVH
`define OESC_DEFINES_SVH
// ****************************************************************
// register map
// ****************************************************************
`define OESC_ADDR_SLOT34   8'h0A
`define OESC_ADDR_SYSCTL   8'h0D
`define OESC_ADDR_OPTCFG   8'h0E
`define OESC_RST_SLOT34    8'h00
`define OESC_RST_SYSCTL    8'h00
`define OESC_RST_OPTCFG    8'h00
// ****************************************************************
// field positions
// ****************************************************************
`define OESC_SYS_STORE_EN  2
`define OESC_SYS_PSAVE     1
`define OESC_SYS_SRST      0
`define OESC_OPT_RGE_LSB   6
`define OESC_OPT_SR_LSB    2
`define OESC_OPT_PW_LSB    0
// ****************************************************************
// counts and rate limits
// ****************************************************************
`define OESC_SRST_CYCLES   4'h8
`define OESC_STORE_DEPTH   32
`define OESC_ELEM_BITS     24
`define OESC_FS_BASE_NA    16'h1000
`define OESC_PW_BASE_US    9'h032
`define OESC_SR_LAST_N1    4'hA
`define OESC_SR_1600       4'h9
`define OESC_SR_1000       4'h8
`define OESC_SR_800        4'h7
`define OESC_SR_400        4'h6
`define OESC_SR_N2_84      4'hE
`define OESC_SR_N2_100     4'hF
`endif

// *** verilog/oesc_pkg.sv ***
// Purpose : types shared by the sampling configuration block
// Assumes : constants come from oesc_defines.svh
// Notes   : one state struct holds every register of the block except the sample store memory
`include "oesc_defines.svh"
package oesc_pkg;
   // ****************************************************************
   // slot types and power states
   // ****************************************************************
   typedef enum logic [3:0] {
      OESC_SLOT_NONE   = 4'h0,
      OESC_SLOT_LED1   = 4'h1,
      OESC_SLOT_LED2   = 4'h2,
      OESC_SLOT_PILOT1 = 4'h5,
      OESC_SLOT_PILOT2 = 4'h6,
      OESC_SLOT_ECG    = 4'h9
   } oesc_slot_t;

   typedef enum logic [1:0] {
      OESC_PWR_RUN   = 2'h0,
      OESC_PWR_DRAIN = 2'h1,
      OESC_PWR_SLEEP = 2'h2
   } oesc_pwr_t;

   // ****************************************************************
   // block state
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  slot34;
      logic        store_en;
      logic        psave;
      logic [3:0]  srst_cnt;
      logic        srst_busy;
      logic [1:0]  rge;
      logic [3:0]  sr;
      logic [1:0]  pw;
      oesc_pwr_t   pstate;
      logic [4:0]  wr_ptr;
      logic [4:0]  rd_ptr;
      logic [5:0]  count;
      logic [23:0] res1;
      logic [23:0] res2;
      logic [23:0] res_ecg;
      logic [7:0]  rdata;
      logic [95:0] pop_data;
      logic        osc_en;
      logic        irq_clr;
      logic [15:0] full_scale;
      logic [8:0]  pw_us;
      logic [11:0] sps;
      logic [1:0]  pulses;
   } oesc_state_t;

   // sample rate in samples per second for a rate code
   function automatic logic [11:0] oesc_sps(input logic [3:0] code);
      unique case (code)
         4'h0, 4'hB: oesc_sps = 12'h00A;
         4'h1, 4'hC: oesc_sps = 12'h014;
         4'h2, 4'hD: oesc_sps = 12'h032;
         4'h3, 4'hE: oesc_sps = 12'h054;
         4'h4, 4'hF: oesc_sps = 12'h064;
         4'h5:       oesc_sps = 12'h0C8;
         4'h6:       oesc_sps = 12'h190;
         4'h7:       oesc_sps = 12'h320;
         4'h8:       oesc_sps = 12'h3E8;
         4'h9:       oesc_sps = 12'h640;
         4'hA:       oesc_sps = 12'hC80;
      endcase
   endfunction : oesc_sps
endpackage : oesc_pkg

// *** dv/oesc_fe_model.sv ***
// Purpose : front-end model that converts on request and reports results
// Assumes : driven at falling edges of core_clk
// Notes   : result lines show inverted data outside the done cycle, slot 1/2 elements show zero
`timescale 1ns/1ns
module oesc_fe_model (
   // clock and reset
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   // conversion control from the bench
   input  wire logic        conv_start,
   input  wire logic        conv_hold,
   // outputs towards the block
   output logic             conv_busy,
   output logic             conv_done,
   output logic      [23:0] first_led_in,
   output logic      [23:0] second_led_in,
   output logic      [23:0] ecg_in,
   output logic      [47:0] slot12_elems
);
   logic [1:0] cnt_ff;
   logic [7:0] idx_ff;

   // busy for four cycles or while held, then one done pulse
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt_ff    <= 2'h0;
         idx_ff    <= 8'h00;
         conv_busy <= 1'b0;
         conv_done <= 1'b0;
      end else begin
         conv_done <= 1'b0;
         if (conv_done) idx_ff <= idx_ff + 8'h01;
         if (conv_start && !conv_busy) begin
            conv_busy <= 1'b1;
            cnt_ff    <= 2'h3;
         end else if (conv_busy) begin
            if (cnt_ff != 2'h0) cnt_ff <= cnt_ff - 2'h1;
            else if (!conv_hold) begin
               conv_busy <= 1'b0;
               conv_done <= 1'b1;
            end
         end
      end
   end

   // results carry the conversion index, inverted when not valid, slot 1/2 elements zero
   assign first_led_in  = conv_done ? {16'h1100, idx_ff} : ~{16'h1100, idx_ff};
   assign second_led_in = conv_done ? {16'h2200, idx_ff} : ~{16'h2200, idx_ff};
   assign ecg_in        = conv_done ? {16'h9900, idx_ff} : ~{16'h9900, idx_ff};
   assign slot12_elems  = conv_done ? {16'hAA00, idx_ff, 16'hBB00, idx_ff} : 48'h0000;
endmodule : oesc_fe_model

// *** dv/tb_oesc_sample_config.sv ***
// Purpose : register-level test of the sampling configuration block
// Assumes : inputs driven at falling edges, outputs read there too
// Notes   : conversions come from oesc_fe_model
`timescale 1ns/1ns
module tb_oesc_sample_config;
   logic core_clk, sys_rst, reg_wr, reg_rd, conv_start, conv_hold, two_led_mode, pop_req;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        conv_busy, conv_done, osc_en, irq_clear, soft_reset_busy;
   logic [23:0] first_led_in, second_led_in, ecg_in;
   logic [47:0] slot12_elems;
   logic [95:0] pop_data;
   logic [5:0]  store_count, cnt_seen;
   logic [3:0]  slot_three_type, slot_four_type;
   logic [15:0] adc_full_scale_na;
   logic [8:0]  led_pulse_width_us;
   logic [11:0] sample_rate_sps;
   logic [1:0]  pulses_per_sample;
   int err_count, checked, n_conv;
   logic [11:0] sps_tab [16] = '{12'h00A, 12'h014, 12'h032, 12'h054, 12'h064, 12'h0C8,
      12'h190, 12'h320, 12'h3E8, 12'h640, 12'hC80, 12'h00A, 12'h014, 12'h032, 12'h054, 12'h064};
   logic [7:0]  slot_tab [5] = '{8'h91, 8'h62, 8'h15, 8'h3F, 8'h0C};
   logic [11:0] clamp_tab [5] = '{12'h0A9, 12'h0A8, 12'h1A6, 12'h197, 12'h1FE};

   oesc_sample_config oesc_sample_config_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .conv_busy(conv_busy), .conv_done(conv_done),
      .first_led_in(first_led_in), .second_led_in(second_led_in), .ecg_in(ecg_in),
      .slot12_elems(slot12_elems), .two_led_mode(two_led_mode), .pop_req(pop_req),
      .pop_data(pop_data), .store_count(store_count), .osc_en(osc_en),
      .irq_clear(irq_clear), .soft_reset_busy(soft_reset_busy),
      .slot_three_type(slot_three_type), .slot_four_type(slot_four_type),
      .adc_full_scale_na(adc_full_scale_na), .led_pulse_width_us(led_pulse_width_us),
      .sample_rate_sps(sample_rate_sps), .pulses_per_sample(pulses_per_sample));
   oesc_fe_model oesc_fe_model_i (.core_clk(core_clk), .sys_rst(sys_rst),
      .conv_start(conv_start), .conv_hold(conv_hold), .conv_busy(conv_busy),
      .conv_done(conv_done), .first_led_in(first_led_in), .second_led_in(second_led_in),
      .ecg_in(ecg_in), .slot12_elems(slot12_elems));

   // 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task close_out;
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out

   task check(input logic [95:0] seen, input logic [95:0] exp);
      checked++;
      if (seen !== exp) begin
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         err_count++;
      end
   endtask : check

   task wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask : wr_reg

   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      check(reg_rdata, exp);
   endtask : rd_chk

   // one conversion, bounded wait on the done pulse
   task convert;
      int i;
      @(negedge core_clk);
      conv_start = 1'b1;
      @(negedge core_clk);
      conv_start = 1'b0;
      for (i = 0; i < 40 && conv_done !== 1'b1; i++) @(negedge core_clk);
      if (i == 40) begin
         err_count++;
         close_out();
      end
      @(negedge core_clk);
      n_conv++;
   endtask : convert

   task pop_chk(input logic [95:0] exp);
      @(negedge core_clk);
      pop_req = 1'b1;
      @(negedge core_clk);
      pop_req = 1'b0;
      check(pop_data, exp);
   endtask : pop_chk

   // element value the store should hold for a slot code
   function automatic logic [23:0] elem(input logic [3:0] c, input logic [7:0] k);
      case (c)
         4'h1, 4'h5: elem = {16'h1100, k};
         4'h2, 4'h6: elem = {16'h2200, k};
         4'h9:       elem = {16'h9900, k};
         default:    elem = 24'h00_0000;
      endcase
   endfunction : elem

   task wait_low(input logic [1:0] which);
      int i;
      for (i = 0; i < 60 && (which == 2'h0 ? soft_reset_busy : osc_en) !== 1'b0; i++)
         @(negedge core_clk);
      if (i == 60) begin
         err_count++;
         close_out();
      end
   endtask : wait_low

   // main sequence
   initial begin
      {sys_rst, reg_wr, reg_rd, conv_start, conv_hold, two_led_mode, pop_req} = 7'h40;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      err_count = 0;
      checked   = 0;
      n_conv    = 0;
      repeat (6) @(negedge core_clk);
      sys_rst = 1'b0;
      rd_chk(8'h0A, 8'h00);
      rd_chk(8'h0D, 8'h00);
      rd_chk(8'h0E, 8'h00);
      rd_chk(8'h0B, 8'h00);
      check(osc_en, 1'b1);
      // slot codes decide elements three and four
      foreach (slot_tab[j]) begin
         wr_reg(8'h0A, slot_tab[j]);
         check({slot_four_type, slot_three_type}, slot_tab[j]);
         wr_reg(8'h0D, 8'h00);
         wr_reg(8'h0D, 8'h04);
         convert();
         pop_chk({16'hAA00, 8'(n_conv - 1), 16'hBB00, 8'(n_conv - 1),
            elem(slot_tab[j][3:0], 8'(n_conv - 1)), elem(slot_tab[j][7:4], 8'(n_conv - 1))});
      end
      wr_reg(8'h0A, 8'h00);
      // enable clear holds the store, setting it flushes
      wr_reg(8'h0D, 8'h00);
      wr_reg(8'h0D, 8'h04);
      convert();
      convert();
      wr_reg(8'h0D, 8'h00);
      convert();
      check(store_count, 6'h02);
      rd_chk(8'h0D, 8'h00);
      wr_reg(8'h0D, 8'h04);
      check(store_count, 6'h00);
      repeat (33) convert();
      check(store_count, 6'h20);
      // range and pulse width codes
      for (int r = 0; r < 4; r++) begin
         wr_reg(8'h0E, 8'((r << 6) | r));
         @(negedge core_clk);
         check(adc_full_scale_na, 16'h1000 << r);
         check(led_pulse_width_us, 9'h032 << r);
      end
      // every rate code at the shortest pulse width
      for (int c = 0; c < 16; c++) begin
         wr_reg(8'h0E, 8'(c << 2));
         @(negedge core_clk);
         check(sample_rate_sps, sps_tab[c]);
         check(pulses_per_sample, (c > 10) ? 2'h2 : 2'h1);
      end
      // unsupported rates are replaced by the highest allowed
      foreach (clamp_tab[j]) begin
         two_led_mode = clamp_tab[j][8];
         wr_reg(8'h0E, {2'h0, clamp_tab[j][7:4], 2'h0} | 8'(clamp_tab[j][11:9] | 2'h0));
         wr_reg(8'h0E, {2'h0, clamp_tab[j][7:4], 2'(j < 2 ? j + 1 : 3 - (j == 3 ? 2 : 0))});
         @(negedge core_clk);
         rd_chk(8'h0E, {2'h0, clamp_tab[j][3:0], 2'(j < 2 ? j + 1 : 3 - (j == 3 ? 2 : 0))});
      end
      two_led_mode = 1'b0;
      // power-save waits for the running conversion, which is still stored, store frozen while asleep
      wr_reg(8'h0D, 8'h00);
      conv_hold = 1'b1;
      @(negedge core_clk);
      conv_start = 1'b1;
      @(negedge core_clk);
      conv_start = 1'b0;
      wr_reg(8'h0D, 8'h06);
      repeat (8) @(negedge core_clk);
      check({osc_en, irq_clear}, 2'h2);
      conv_hold = 1'b0;
      wait_low(2'h1);
      @(negedge core_clk);
      check(irq_clear, 1'b1);
      check(store_count, 6'h01);
      cnt_seen = store_count;
      convert();
      check(store_count, cnt_seen);
      wr_reg(8'h0A, 8'h29);
      rd_chk(8'h0A, 8'h29);
      wr_reg(8'h0D, 8'h04);
      @(negedge core_clk);
      check({osc_en, irq_clear}, 2'h2);
      // soft reset returns registers and clears itself
      wr_reg(8'h0E, 8'hC5);
      wr_reg(8'h0D, 8'h05);
      check(soft_reset_busy, 1'b1);
      wait_low(2'h0);
      rd_chk(8'h0D, 8'h00);
      rd_chk(8'h0A, 8'h00);
      rd_chk(8'h0E, 8'h00);
      check(store_count, 6'h00);
      close_out();
   end
endmodule : tb_oesc_sample_config
